// >>> core/vsc_pkg.sv
`default_nettype none

package vsc_pkg;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_CLEAR_FAULTS    = 8'h03;
	localparam logic [7:0] CMD_OV_FAULT_ACTION = 8'h41;
	localparam logic [7:0] CMD_OV_WARN_THRESH  = 8'h42;
	localparam logic [7:0] CMD_UV_WARN_THRESH  = 8'h43;
	localparam logic [7:0] CMD_STATUS_WORD     = 8'h79;
	localparam logic [7:0] CMD_STATUS_VOUT     = 8'h7A;
	localparam logic [7:0] CMD_COMMS_STATUS    = 8'h7E;

	// ----------------------------------------------------------------
	// Reset values and field layout
	// ----------------------------------------------------------------
	localparam logic [7:0]  OV_ACTION_RESET   = 8'hBF;
	localparam logic [15:0] OV_WARN_RESET     = 16'h0267;
	localparam logic [15:0] UV_WARN_RESET     = 16'h0143;
	localparam logic [15:0] THRESH_WR_MASK    = 16'h0FFF;
	localparam logic [15:0] FAULT_ROUND_MASK  = 16'hFFF0;
	localparam logic [2:0]  RESTART_DELAY_RO  = 3'h7;
	localparam logic [2:0]  RETRY_NONE        = 3'h0;
	localparam logic [2:0]  RETRY_FOREVER     = 3'h7;
	localparam int          ACT_SHUTDOWN_BIT  = 7;
	localparam int          ACT_ZERO_BIT      = 6;
	localparam int          ACT_RETRY_HI      = 5;
	localparam int          ACT_RETRY_LO      = 3;
	localparam logic [2:0]  RESTART_RISES_M1  = 3'h6;

	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int SW_VOUT_BIT   = 15;
	localparam int SB_OV_BIT     = 5;
	localparam int SB_CML_BIT    = 1;
	localparam int SB_OTHER_BIT  = 0;
	localparam int SV_OVF_BIT    = 7;
	localparam int SV_OVW_BIT    = 6;
	localparam int SV_UVW_BIT    = 5;
	localparam int SV_UVF_BIT    = 4;
	localparam int CML_CMD_BIT   = 7;
	localparam int CML_IVD_BIT   = 6;

	// ----------------------------------------------------------------
	// Range limits on threshold times loop scale
	// ----------------------------------------------------------------
	localparam int OV_WARN_MIN_PRODUCT = 269;
	localparam int UV_WARN_MIN_PRODUCT = 178;
	localparam int UV_WARN_MAX_PRODUCT = 732;
	localparam int UV_DISABLED_NUM     = 179;

	// ----------------------------------------------------------------
	// Fault action sequencer and block state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FA_RUN,
		FA_HELD,
		FA_WAIT
	} vsc_fsm_type;

	typedef struct packed {
		logic [7:0]  ov_action;
		logic [15:0] ov_warn;
		logic [15:0] uv_warn;
		logic [15:0] status_word;
		logic [7:0]  status_vout;
		logic [7:0]  comms_status;
		logic        alert;
		logic        uv_armed;
		vsc_fsm_type fsm;
		logic [15:0] wait_cnt;
		logic [2:0]  rise_idx;
		logic        shutdown;
		logic        restart;
		logic        rsp_valid;
		logic [15:0] rsp_data;
		logic [1:0]  nvm_image;
	} vsc_state_type;

endpackage

`default_nettype wire

// >>> core/vsc_chk_if.sv
`timescale 1ns/1ns
`default_nettype none

interface vsc_chk_if #(
	parameter int SCALE_W = 8
);
	logic [7:0]         code;
	logic [15:0]        data;
	logic [15:0]        ovf;
	logic [15:0]        uvf;
	logic [15:0]        setpoint;
	logic [SCALE_W-1:0] scale;
	logic               accept;
	logic [15:0]        ov_default;
	logic [15:0]        uv_default;

	modport asker (output code, data, ovf, uvf, setpoint, scale, input accept, ov_default, uv_default);
	modport judge (input code, data, ovf, uvf, setpoint, scale, output accept, ov_default, uv_default);
endinterface

`default_nettype wire

// >>> core/vsc_limit_check.sv
`timescale 1ns/1ns
`default_nettype none

module vsc_limit_check #(
	parameter int SCALE_W = 8
) (
	// Check request and verdict
	vsc_chk_if.judge chk
);
	localparam int PW = 16 + SCALE_W;

	logic [15:0]   mant;
	logic [PW-1:0] prod;
	logic [2:0]    retry;
	logic [15:0]   ov_cand;
	logic [15:0]   uv_cand;
	logic [15:0]   uv_min;

	// ----------------------------------------------------------------
	// Range check of a write
	// ----------------------------------------------------------------
	always_comb begin
		mant  = chk.data & vsc_pkg::THRESH_WR_MASK;
		prod  = PW'(mant) * PW'(chk.scale);
		retry = chk.data[vsc_pkg::ACT_RETRY_HI:vsc_pkg::ACT_RETRY_LO];
		unique case (chk.code)
			vsc_pkg::CMD_OV_FAULT_ACTION: begin
				chk.accept = (retry == vsc_pkg::RETRY_NONE) || (retry == vsc_pkg::RETRY_FOREVER);
			end
			vsc_pkg::CMD_OV_WARN_THRESH: begin
				chk.accept = (mant > chk.setpoint) && (mant < chk.ovf)
					&& (prod > PW'(vsc_pkg::OV_WARN_MIN_PRODUCT));
			end
			vsc_pkg::CMD_UV_WARN_THRESH: begin
				chk.accept = (mant > chk.uvf) && (mant < chk.setpoint)
					&& (prod > PW'(vsc_pkg::UV_WARN_MIN_PRODUCT))
					&& (prod < PW'(vsc_pkg::UV_WARN_MAX_PRODUCT));
			end
			default: begin
				chk.accept = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Default warning thresholds derived from the fault thresholds
	// ----------------------------------------------------------------
	always_comb begin
		ov_cand = chk.ovf - (chk.ovf >> 4);
		uv_cand = chk.uvf + (chk.uvf >> 4);
		uv_min  = (chk.scale == '0) ? 16'h0000 : 16'(vsc_pkg::UV_DISABLED_NUM / int'(chk.scale));
		if (ov_cand > chk.setpoint) begin
			chk.ov_default = ov_cand & vsc_pkg::THRESH_WR_MASK;
		end else begin
			chk.ov_default = (chk.ovf - 16'h0001) & vsc_pkg::THRESH_WR_MASK;
		end
		if (chk.uvf == 16'h0000) begin
			chk.uv_default = uv_min & vsc_pkg::THRESH_WR_MASK;
		end else if (uv_cand < chk.setpoint) begin
			chk.uv_default = uv_cand & vsc_pkg::THRESH_WR_MASK;
		end else begin
			chk.uv_default = ((chk.uvf & vsc_pkg::FAULT_ROUND_MASK) + 16'h0001) & vsc_pkg::THRESH_WR_MASK;
		end
	end
endmodule

`default_nettype wire

// >>> core/vsc_vout_config.sv
//
// Function
// - Overvoltage fault sets summary, word and output status bits and raises alert.
// - Fault action register picks the reaction and can be saved to nonvolatile store.
// - Action bits 2:0 read as seven, bit 6 reads as zero.
// - Action register resets to shutdown with continuous restart, value BF.
// - Shutdown bit clear: keep running but flag status and alert.
// - Retry 000: stay off after shutdown until faults are cleared or the output is commanded off.
// - Retry 111: restart after delay, repeating until commanded off.
// - Retry values other than 000 or 111 are refused with comms error and alert.
// - Only retry bit 5 is saved; the other two are restored from it.
// - Out-of-range overvoltage warning write refused, value kept, comms error and alert.
// - Overvoltage warning must exceed setpoint, stay below fault, product above 269.
// - Overvoltage warning sets other, output and warning status bits plus alert.
// - Warning thresholds are 12-bit mantissas; top four bits read-only zero.
// - Overvoltage warning threshold resets to 615.
// - Default overvoltage warning is fault minus a sixteenth, else fault minus one.
// - Undervoltage warning ignored before first regulation and while disabled.
// - Out-of-range undervoltage warning write refused, value kept, comms error and alert.
// - Undervoltage warning between fault and setpoint, product strictly within 178 and 732.
// - Undervoltage warning sets other, output and warning status bits plus alert.
// - Default undervoltage warning is fault plus a sixteenth, else rounded fault plus one.
// - With undervoltage fault disabled, default warning is 179 over loop scale.
// - Undervoltage warning threshold resets to 323.
// - Zero undervoltage fault threshold disables its checking, not the warning.
`timescale 1ns/1ns
`default_nettype none

module vsc_vout_config #(
	parameter int SCALE_W = 8
) (
	// Clock and reset
	input  wire logic               clock_i,
	input  wire logic               sys_rst_i,
	// Command port
	input  wire logic               cmd_valid_i,
	input  wire logic               cmd_write_i,
	input  wire logic [7:0]         cmd_code_i,
	input  wire logic [15:0]        cmd_data_i,
	output var  logic               rsp_valid_o,
	output var  logic [15:0]        rsp_data_o,
	// Converter context
	input  wire logic [15:0]        ov_fault_threshold_i,
	input  wire logic [15:0]        uv_fault_threshold_i,
	input  wire logic [15:0]        vout_setpoint_i,
	input  wire logic [SCALE_W-1:0] scale_loop_i,
	input  wire logic [15:0]        rise_cycles_i,
	// Supervision inputs
	input  wire logic [15:0]        vout_meas_i,
	input  wire logic               meas_valid_i,
	input  wire logic               output_enabled_i,
	input  wire logic               ov_fault_i,
	input  wire logic               uv_fault_i,
	// Nonvolatile store and defaults
	input  wire logic               store_all_i,
	input  wire logic               restore_i,
	input  wire logic [1:0]         nvm_image_i,
	input  wire logic               load_defaults_i,
	output var  logic [1:0]         nvm_image_o,
	// Status and power control
	output var  logic [15:0]        status_word_o,
	output var  logic [7:0]         status_vout_o,
	output var  logic [7:0]         comms_status_o,
	output var  logic               alert_o,
	output var  logic               shutdown_o,
	output var  logic               restart_o
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (SCALE_W < 1 || SCALE_W > 8) begin : g_bad_scale
		$error("SCALE_W must lie between 1 and 8");
	end

	vsc_pkg::vsc_state_type st_q;
	vsc_pkg::vsc_state_type st_d;
	vsc_chk_if #(.SCALE_W(SCALE_W)) chk ();

	logic        wr_act;
	logic        wr_ovw;
	logic        wr_uvw;
	logic        wr_clr;
	logic        ov_warn_hit;
	logic        uv_warn_hit;
	logic        uvf_hit;
	logic        rise_end;
	logic [15:0] rise_last;
	logic [2:0]  retry_q;

	// ----------------------------------------------------------------
	// Range checker and default derivation
	// ----------------------------------------------------------------
	assign chk.code     = cmd_code_i;
	assign chk.data     = cmd_data_i;
	assign chk.ovf      = ov_fault_threshold_i;
	assign chk.uvf      = uv_fault_threshold_i;
	assign chk.setpoint = vout_setpoint_i;
	assign chk.scale    = scale_loop_i;

	vsc_limit_check #(
		.SCALE_W (SCALE_W)
	) u_check (
		.chk (chk)
	);

	// ----------------------------------------------------------------
	// Decode and detection terms
	// ----------------------------------------------------------------
	assign wr_act      = cmd_valid_i && cmd_write_i && (cmd_code_i == vsc_pkg::CMD_OV_FAULT_ACTION);
	assign wr_ovw      = cmd_valid_i && cmd_write_i && (cmd_code_i == vsc_pkg::CMD_OV_WARN_THRESH);
	assign wr_uvw      = cmd_valid_i && cmd_write_i && (cmd_code_i == vsc_pkg::CMD_UV_WARN_THRESH);
	assign wr_clr      = cmd_valid_i && cmd_write_i && (cmd_code_i == vsc_pkg::CMD_CLEAR_FAULTS);
	assign ov_warn_hit = meas_valid_i && (vout_meas_i > st_q.ov_warn);
	assign uv_warn_hit = meas_valid_i && st_q.uv_armed && output_enabled_i
		&& (vout_meas_i < st_q.uv_warn);
	assign uvf_hit     = uv_fault_i && (uv_fault_threshold_i != 16'h0000);
	assign rise_last   = (rise_cycles_i == 16'h0000) ? 16'h0000 : rise_cycles_i - 16'h0001;
	assign rise_end    = (st_q.wait_cnt >= rise_last);
	assign retry_q     = st_q.ov_action[vsc_pkg::ACT_RETRY_HI:vsc_pkg::ACT_RETRY_LO];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d           = st_q;
		st_d.rsp_valid = 1'b0;
		st_d.restart   = 1'b0;

		// Host clear first, so any event in the same cycle wins
		if (wr_clr) begin
			st_d.status_word  = 16'h0000;
			st_d.status_vout  = 8'h00;
			st_d.comms_status = 8'h00;
		end

		// Register writes
		if (wr_act || wr_ovw || wr_uvw) begin
			if (chk.accept) begin
				if (wr_act) begin
					st_d.ov_action = {cmd_data_i[vsc_pkg::ACT_SHUTDOWN_BIT], 1'b0,
						cmd_data_i[vsc_pkg::ACT_RETRY_HI:vsc_pkg::ACT_RETRY_LO], vsc_pkg::RESTART_DELAY_RO};
				end else if (wr_ovw) begin
					st_d.ov_warn = cmd_data_i & vsc_pkg::THRESH_WR_MASK;
				end else begin
					st_d.uv_warn = cmd_data_i & vsc_pkg::THRESH_WR_MASK;
				end
			end else begin
				st_d.comms_status[vsc_pkg::CML_IVD_BIT] = 1'b1;
				st_d.status_word[vsc_pkg::SB_CML_BIT]   = 1'b1;
			end
		end else if (cmd_valid_i && cmd_write_i && !wr_clr) begin
			st_d.comms_status[vsc_pkg::CML_CMD_BIT] = 1'b1;
			st_d.status_word[vsc_pkg::SB_CML_BIT]   = 1'b1;
		end

		// Register reads
		if (cmd_valid_i && !cmd_write_i) begin
			st_d.rsp_valid = 1'b1;
			unique case (cmd_code_i)
				vsc_pkg::CMD_OV_FAULT_ACTION: st_d.rsp_data = {8'h00, st_q.ov_action};
				vsc_pkg::CMD_OV_WARN_THRESH:  st_d.rsp_data = st_q.ov_warn;
				vsc_pkg::CMD_UV_WARN_THRESH:  st_d.rsp_data = st_q.uv_warn;
				vsc_pkg::CMD_STATUS_WORD:     st_d.rsp_data = st_q.status_word;
				vsc_pkg::CMD_STATUS_VOUT:     st_d.rsp_data = {8'h00, st_q.status_vout};
				vsc_pkg::CMD_COMMS_STATUS:    st_d.rsp_data = {8'h00, st_q.comms_status};
				default: begin
					st_d.rsp_data                           = 16'h0000;
					st_d.comms_status[vsc_pkg::CML_CMD_BIT] = 1'b1;
					st_d.status_word[vsc_pkg::SB_CML_BIT]   = 1'b1;
				end
			endcase
		end

		// Nonvolatile save and restore of the action register
		if (store_all_i) begin
			st_d.nvm_image = {st_q.ov_action[vsc_pkg::ACT_SHUTDOWN_BIT], st_q.ov_action[vsc_pkg::ACT_RETRY_HI]};
		end
		if (restore_i) begin
			st_d.ov_action = {nvm_image_i[1], 1'b0, {3{nvm_image_i[0]}}, vsc_pkg::RESTART_DELAY_RO};
		end
		if (load_defaults_i) begin
			st_d.ov_warn = chk.ov_default;
			st_d.uv_warn = chk.uv_default;
		end

		// Undervoltage arming: first regulation, dropped when disabled
		if (!output_enabled_i) begin
			st_d.uv_armed = 1'b0;
		end else if (meas_valid_i && vout_meas_i >= vout_setpoint_i) begin
			st_d.uv_armed = 1'b1;
		end

		// Warning and fault status, sticky until cleared
		if (ov_fault_i) begin
			st_d.status_word[vsc_pkg::SB_OV_BIT]   = 1'b1;
			st_d.status_word[vsc_pkg::SW_VOUT_BIT] = 1'b1;
			st_d.status_vout[vsc_pkg::SV_OVF_BIT]  = 1'b1;
		end
		if (ov_warn_hit) begin
			st_d.status_word[vsc_pkg::SB_OTHER_BIT] = 1'b1;
			st_d.status_word[vsc_pkg::SW_VOUT_BIT]  = 1'b1;
			st_d.status_vout[vsc_pkg::SV_OVW_BIT]   = 1'b1;
		end
		if (uv_warn_hit) begin
			st_d.status_word[vsc_pkg::SB_OTHER_BIT] = 1'b1;
			st_d.status_word[vsc_pkg::SW_VOUT_BIT]  = 1'b1;
			st_d.status_vout[vsc_pkg::SV_UVW_BIT]   = 1'b1;
		end
		if (uvf_hit) begin
			st_d.status_word[vsc_pkg::SB_OTHER_BIT] = 1'b1;
			st_d.status_word[vsc_pkg::SW_VOUT_BIT]  = 1'b1;
			st_d.status_vout[vsc_pkg::SV_UVF_BIT]   = 1'b1;
		end
		st_d.alert = (st_d.status_word != 16'h0000) || (st_d.status_vout != 8'h00)
			|| (st_d.comms_status != 8'h00);

		// Fault action sequencer
		unique case (st_q.fsm)
			vsc_pkg::FA_RUN: begin
				st_d.shutdown = 1'b0;
				if (ov_fault_i && st_q.ov_action[vsc_pkg::ACT_SHUTDOWN_BIT]) begin
					st_d.shutdown = 1'b1;
					st_d.wait_cnt = 16'h0000;
					st_d.rise_idx = 3'h0;
					st_d.fsm      = (retry_q == vsc_pkg::RETRY_NONE) ? vsc_pkg::FA_HELD : vsc_pkg::FA_WAIT;
				end
			end
			vsc_pkg::FA_HELD: begin
				if (wr_clr || !output_enabled_i) begin
					st_d.shutdown = 1'b0;
					st_d.restart  = output_enabled_i;
					st_d.fsm      = vsc_pkg::FA_RUN;
				end
			end
			vsc_pkg::FA_WAIT: begin
				if (!output_enabled_i) begin
					st_d.shutdown = 1'b0;
					st_d.fsm      = vsc_pkg::FA_RUN;
				end else if (rise_end) begin
					st_d.wait_cnt = 16'h0000;
					st_d.rise_idx = st_q.rise_idx + 3'h1;
					if (st_q.rise_idx == vsc_pkg::RESTART_RISES_M1) begin
						st_d.shutdown = 1'b0;
						st_d.restart  = 1'b1;
						st_d.fsm      = vsc_pkg::FA_RUN;
					end
				end else begin
					st_d.wait_cnt = st_q.wait_cnt + 16'h0001;
				end
			end
			default: begin
				st_d.shutdown = 1'b0;
				st_d.fsm      = vsc_pkg::FA_RUN;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			st_q              <= '0;
			st_q.ov_action    <= vsc_pkg::OV_ACTION_RESET;
			st_q.ov_warn      <= vsc_pkg::OV_WARN_RESET;
			st_q.uv_warn      <= vsc_pkg::UV_WARN_RESET;
			st_q.fsm          <= vsc_pkg::FA_RUN;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rsp_valid_o    = st_q.rsp_valid;
	assign rsp_data_o     = st_q.rsp_data;
	assign nvm_image_o    = st_q.nvm_image;
	assign status_word_o  = st_q.status_word;
	assign status_vout_o  = st_q.status_vout;
	assign comms_status_o = st_q.comms_status;
	assign alert_o        = st_q.alert;
	assign shutdown_o     = st_q.shutdown;
	assign restart_o      = st_q.restart;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_OVF_STATUS: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ov_fault_i |=> status_vout_o[vsc_pkg::SV_OVF_BIT] && status_word_o[vsc_pkg::SB_OV_BIT]
			&& status_word_o[vsc_pkg::SW_VOUT_BIT] && alert_o)
		else $error("overvoltage fault status not set");

	AST_ACTION_FIXED: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(st_q.ov_action[2:0] == 3'h7) && !st_q.ov_action[6])
		else $error("fixed action bits wrong");

	AST_RESET_VALUES: assert property (@(posedge clock_i)
		$past(sys_rst_i) && !sys_rst_i |-> (st_q.ov_action == 8'hBF) && (st_q.ov_warn == 16'h0267)
			&& (st_q.uv_warn == 16'h0143) && !shutdown_o)
		else $error("reset values wrong");

	AST_IGNORE_MODE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ov_fault_i && !st_q.ov_action[7] && (st_q.fsm == vsc_pkg::FA_RUN) && !restore_i
			|=> !shutdown_o && alert_o)
		else $error("ignore mode shut down");

	AST_LATCH_OFF: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(st_q.fsm == vsc_pkg::FA_HELD) && !wr_clr && output_enabled_i |=> shutdown_o && !restart_o)
		else $error("latched off left early");

	AST_RESTART: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(st_q.fsm == vsc_pkg::FA_WAIT) && output_enabled_i && rise_end && (st_q.rise_idx == 3'h6)
			|=> restart_o && !shutdown_o)
		else $error("restart missing after delay");

	AST_BAD_RETRY: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wr_act && (cmd_data_i[5:3] != 3'h0) && (cmd_data_i[5:3] != 3'h7) && !restore_i
			|=> comms_status_o[vsc_pkg::CML_IVD_BIT] && alert_o && $stable(st_q.ov_action))
		else $error("bad retry value not refused");

	AST_NVM_BIT5: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		store_all_i |=> nvm_image_o == {$past(st_q.ov_action[7]), $past(st_q.ov_action[5])})
		else $error("nonvolatile image wrong");

	AST_OVW_REJECT: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wr_ovw && !chk.accept && !load_defaults_i |=> $stable(st_q.ov_warn)
			&& comms_status_o[vsc_pkg::CML_IVD_BIT] && status_word_o[vsc_pkg::SB_CML_BIT])
		else $error("bad overvoltage warning kept");

	AST_UV_MASK: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!st_q.uv_armed && !uvf_hit && !status_vout_o[vsc_pkg::SV_UVW_BIT] |=> !status_vout_o[vsc_pkg::SV_UVW_BIT])
		else $error("undervoltage warning while masked");

endmodule

`default_nettype wire

// >>> testbench/vsc_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module vsc_host_model (
	// Clock
	input  wire logic        clock_i,
	// Command port
	output var  logic        cmd_valid_o,
	output var  logic        cmd_write_o,
	output var  logic [7:0]  cmd_code_o,
	output var  logic [15:0] cmd_data_o,
	input  wire logic        rsp_valid_i,
	input  wire logic [15:0] rsp_data_i
);
	// ----------
	// Idle bus
	// ----------
	initial begin
		cmd_valid_o = 1'b0;
		cmd_write_o = 1'b0;
		cmd_code_o = 8'h00;
		cmd_data_o = 16'h0000;
	end

	// One command, launched and released at falling edges
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data, output logic [15:0] rd);
		@(negedge clock_i);
		cmd_valid_o = 1'b1;
		cmd_write_o = wr;
		cmd_code_o = code;
		cmd_data_o = data;
		@(negedge clock_i);
		rd = (rsp_valid_i === 1'b1) ? rsp_data_i : 16'hXXXX;
		// Released code and data lines must not keep their last value
		cmd_valid_o = 1'b0;
		cmd_code_o = ~code;
		cmd_data_o = ~data;
	endtask
endmodule

`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
	// ----------
	// Signals
	// ----------
	logic        clock_i, sys_rst_i, cmd_valid_i, cmd_write_i, meas_valid_i, output_enabled_i, ok, hit;
	logic        ov_fault_i, uv_fault_i, store_all_i, restore_i, load_defaults_i;
	logic        rsp_valid_o, alert_o, shutdown_o, restart_o;
	logic [1:0]  nvm_image_i, nvm_image_o;
	logic [7:0]  cmd_code_i, status_vout_o, comms_status_o, scale_loop_i, c;
	logic [15:0] cmd_data_i, rsp_data_o, ov_fault_threshold_i, uv_fault_threshold_i, vout_setpoint_i, rd, v;
	logic [15:0] rise_cycles_i, vout_meas_i, status_word_o;
	logic [15:0] thr [2];
	logic [15:0] cor [8] = '{16'h0191, 16'h0131, 16'h0190, 16'h0130, 16'h028F, 16'h018F, 16'h0290, 16'h0190};
	int          err_count = 0, cmp_count = 0, seed = 16, i, n;

	vsc_host_model host_u (.clock_i, .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
		.cmd_code_o(cmd_code_i), .cmd_data_o(cmd_data_i), .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o));

	vsc_vout_config #(.SCALE_W(8)) dut_u (.clock_i, .sys_rst_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i,
		.cmd_data_i, .rsp_valid_o, .rsp_data_o, .ov_fault_threshold_i, .uv_fault_threshold_i, .vout_setpoint_i,
		.scale_loop_i, .rise_cycles_i, .vout_meas_i, .meas_valid_i, .output_enabled_i, .ov_fault_i, .uv_fault_i,
		.store_all_i, .restore_i, .nvm_image_i, .load_defaults_i, .nvm_image_o, .status_word_o, .status_vout_o,
		.comms_status_o, .alert_o, .shutdown_o, .restart_o);

	// 100 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// ----------
	// Helpers
	// ----------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rdc(input logic [7:0] code, input logic [15:0] exp);
		host_u.xfer(1'b0, code, 16'h0000, rd);
		check("read", rd, exp);
	endtask

	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		host_u.xfer(1'b1, code, data, rd);
	endtask

	task automatic clr;
		wr(8'h03, 16'h0000);
	endtask

	// Range test of a warning threshold write
	function automatic logic acc(input logic [7:0] code, input logic [15:0] d);
		logic [31:0] m;
		m = 32'(d[11:0]);
		if (code == 8'h42)
			return m > 32'(vout_setpoint_i) && m < 32'(ov_fault_threshold_i) && m * scale_loop_i > 32'h010D;
		return m > 32'(uv_fault_threshold_i) && m < 32'(vout_setpoint_i) && m * scale_loop_i > 32'h00B2
			&& m * scale_loop_i < 32'h02DC;
	endfunction

	// Derived defaults for one converter context
	task automatic dflt(input logic [15:0] sp, uf, input logic [7:0] sc, input logic [15:0] eo, eu);
		vout_setpoint_i = sp;
		uv_fault_threshold_i = uf;
		scale_loop_i = sc;
		load_defaults_i = 1'b1;
		@(negedge clock_i);
		load_defaults_i = 1'b0;
		rdc(8'h42, eo);
		rdc(8'h43, eu);
	endtask

	// One overvoltage fault pulse and its status
	task automatic ovf(input logic sd);
		clr;
		ov_fault_i = 1'b1;
		@(negedge clock_i);
		ov_fault_i = 1'b0;
		check("shutdown", 16'(shutdown_o), 16'(sd));
		check("word", status_word_o, 16'h8020);
		check("vout", 16'(status_vout_o), 16'h0080);
		check("alert", 16'(alert_o), 16'h0001);
	endtask

	task automatic give_verdict;
		$display("Comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Hang guard
	initial begin
		#200000;
		err_count++;
		give_verdict;
	end

	// ----------
	// Scenarios
	// ----------
	initial begin
		sys_rst_i = 1'b1;
		{meas_valid_i, output_enabled_i, ov_fault_i, uv_fault_i} = 4'h0;
		{store_all_i, restore_i, load_defaults_i} = 3'h0;
		nvm_image_i = 2'b00;
		ov_fault_threshold_i = 16'h0290;
		uv_fault_threshold_i = 16'h0130;
		vout_setpoint_i = 16'h0190;
		scale_loop_i = 8'h01;
		rise_cycles_i = 16'h0002;
		vout_meas_i = 16'h0000;
		thr[0] = 16'h0267;
		thr[1] = 16'h0143;
		repeat (10) @(negedge clock_i);
		sys_rst_i = 1'b0;
		rdc(8'h41, 16'h00BF);
		rdc(8'h42, 16'h0267);
		rdc(8'h43, 16'h0143);
		// Mixed retry codes are refused
		for (i = 1; i < 7; i++) begin
			wr(8'h41, {8'h00, 2'b10, 3'(i), 3'b111});
			check("comms", 16'(comms_status_o), 16'h0040);
			check("word", status_word_o, 16'h0002);
			check("alert", 16'(alert_o), 16'h0001);
			rdc(8'h41, 16'h00BF);
			clr;
		end
		// Unknown codes flagged and held until cleared
		wr(8'h55, 16'h0000);
		rdc(8'h55, 16'h0000);
		rdc(8'h7E, 16'h0080);
		rdc(8'h79, 16'h0002);
		clr;
		// Boundary then random threshold writes
		for (i = 0; i < 48; i++) begin
			c = i[0] ? 8'h43 : 8'h42;
			v = 16'($random(seed));
			v[11:0] = i < 8 ? cor[i][11:0] : 12'h0B0 + 12'(v[8:0]);
			scale_loop_i = i[1] ? 8'h02 : 8'h01;
			vout_setpoint_i = i[3] ? 16'h0064 : 16'h0190;
			ok = acc(c, v);
			if (ok)
				thr[c[0]] = 16'(v[11:0]);
			wr(c, v);
			check("comms", 16'(comms_status_o), ok ? 16'h0000 : 16'h0040);
			rdc(c, thr[c[0]]);
			clr;
		end
		dflt(16'h026C, 16'h0000, 8'h02, 16'h028F, 16'h0059);
		dflt(16'h0140, 16'h0135, 8'h01, 16'h0267, 16'h0131);
		dflt(16'h0190, 16'h0130, 8'h01, 16'h0267, 16'h0143);
		// Overvoltage warning
		meas_valid_i = 1'b1;
		vout_meas_i = 16'h02BC;
		@(negedge clock_i);
		vout_meas_i = 16'h00C8;
		check("word", status_word_o, 16'h8001);
		check("vout", 16'(status_vout_o), 16'h0040);
		clr;
		// Undervoltage warning masked until regulation
		output_enabled_i = 1'b1;
		repeat (3) @(negedge clock_i);
		check("vout", 16'(status_vout_o), 16'h0000);
		vout_meas_i = 16'h0190;
		@(negedge clock_i);
		vout_meas_i = 16'h00C8;
		repeat (2) @(negedge clock_i);
		check("vout", 16'(status_vout_o), 16'h0020);
		check("word", status_word_o, 16'h8001);
		rdc(8'h7A, 16'h0020);
		output_enabled_i = 1'b0;
		clr;
		repeat (2) @(negedge clock_i);
		check("vout", 16'(status_vout_o), 16'h0000);
		// Undervoltage fault reported only with a nonzero threshold
		for (i = 0; i < 2; i++) begin
			uv_fault_threshold_i = i[0] ? 16'h0000 : 16'h0130;
			uv_fault_i = 1'b1;
			@(negedge clock_i);
			uv_fault_i = 1'b0;
			check("uvf", 16'(status_vout_o), i[0] ? 16'h0000 : 16'h0010);
			check("alert", 16'(alert_o), i[0] ? 16'h0000 : 16'h0001);
			clr;
		end
		meas_valid_i = 1'b0;
		output_enabled_i = 1'b1;
		// Endless restart after seven rise times
		ovf(1'b1);
		n = 1;
		while (restart_o !== 1'b1 && n < 100) begin
			@(negedge clock_i);
			n++;
		end
		check("delay", 16'(n), 16'h000F);
		check("shutdown", 16'(shutdown_o), 16'h0000);
		wr(8'h41, 16'h0078);
		rdc(8'h41, 16'h003F);
		ovf(1'b0);
		wr(8'h41, 16'h00C0);
		rdc(8'h41, 16'h0087);
		ovf(1'b1);
		hit = 1'b0;
		repeat (30) begin
			@(negedge clock_i);
			hit |= restart_o | ~shutdown_o;
		end
		check("held", 16'(hit), 16'h0000);
		clr;
		check("restart", 16'(restart_o), 16'h0001);
		// Save and restore of the action register
		store_all_i = 1'b1;
		@(negedge clock_i);
		store_all_i = 1'b0;
		@(negedge clock_i);
		check("image", 16'(nvm_image_o), 16'h0002);
		nvm_image_i = 2'b01;
		restore_i = 1'b1;
		@(negedge clock_i);
		restore_i = 1'b0;
		rdc(8'h41, 16'h003F);
		// Second reset in mid-run brings back the reset values
		sys_rst_i = 1'b1;
		repeat (2) @(negedge clock_i);
		sys_rst_i = 1'b0;
		rdc(8'h41, 16'h00BF);
		rdc(8'h43, 16'h0143);
		give_verdict;
	end
endmodule

`default_nettype wire
